// *** shared/gpc_pkg.sv ***
// Purpose: Shared constants and types for the pin configuration bank.
// Assumes: Register index times four gives the APB byte address.
// Notes:   Pin slots are 0..5 for pins 3.7, 4.0, 4.1, 4.2, 4.3, 5.0.
package gpc_pkg;
    localparam int GPC_NPINS = 6;
    localparam int GPC_AW    = 12;
    localparam int GPC_IRQ_W = 3;
    // ****************************************************************
    // Pin slots
    // ****************************************************************
    localparam int GPC_P37 = 0;
    localparam int GPC_P40 = 1;
    localparam int GPC_P41 = 2;
    localparam int GPC_P42 = 3;
    localparam int GPC_P43 = 4;
    localparam int GPC_P50 = 5;
    // ****************************************************************
    // Register indices
    // ****************************************************************
    localparam logic [7:0] GPC_CFG_IDX [GPC_NPINS] =
        '{8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h3F};
    localparam logic [7:0] GPC_IDX_DOUT = 8'h48;
    localparam logic [7:0] GPC_IDX_DIN  = 8'h49;
    localparam logic [7:0] GPC_IDX_IST  = 8'h4A;
    localparam logic [7:0] GPC_IDX_IMSK = 8'h4B;
    localparam logic [7:0] GPC_IDX_LOCK = 8'h4C;
    // ****************************************************************
    // Reset values and writable bits
    // ****************************************************************
    localparam logic [7:0] GPC_CFG_RST = 8'h01;
    localparam logic [7:0] GPC_CFG_WMASK [GPC_NPINS] =
        '{8'h87, 8'h87, 8'h8F, 8'h87, 8'h8F, 8'h83};
    // ****************************************************************
    // Alternate function encodings
    // ****************************************************************
    localparam logic [1:0] GPC_ALT_GPIO  = 2'h0;
    localparam logic [1:0] GPC_ALT41_DEN = 2'h1;
    localparam logic [1:0] GPC_ALT41_EDG = 2'h2;
    localparam logic [1:0] GPC_ALT43_LCK = 2'h1;
    localparam logic [1:0] GPC_ALT43_EDG = 2'h3;
    // ****************************************************************
    // Interrupt status bits
    // ****************************************************************
    localparam int GPC_IRQ_EDGE2 = 0;
    localparam int GPC_IRQ_EDGE3 = 1;
    localparam int GPC_IRQ_LOCK  = 2;
    typedef struct packed {
        logic       open_drain;
        logic [2:0] rsvd;
        logic [1:0] alt;
        logic       invert;
        logic       dir_in;
    } gpc_cfg_s;
endpackage

// *** src/gpc_pin_config_bank.sv ***
// Purpose: Configuration and pin drive logic for six GPIO pins.
// Assumes: Pin inputs are synchronous to pclk; presetn is standby POR.
// Notes:   main_reset stands for main-power POR and hard reset.
// Summary of operation
// - Bit 0 set makes the pin an input, clear makes it an output.
// - Bit 1 set inverts the signal between pin and logic.
// - Bit 7 set gives open-drain drive, clear gives push-pull.
// - Pin 3.7 bit 2 set routes the address line mask to the pin.
// - Pin 4.0 bit 2 set routes drive density select 0.
// - Pin 4.1 bits 3:2: 10 edge interrupt 2, 01 density select 1.
// - Pin 4.2 bit 2 set routes the power event signal.
// - Power event output with no inversion is active low, any driver.
// - Pin 4.3 bits 3:2 equal 11 select edge interrupt input 3.
// - Pin 4.3 mode 01 is lock control; pin is a plain input.
// - Lock mode bits ignore writes; only the resets clear them.
// - Lock mode and pin 4.3 high make the disable register read-only.
// - Lock mode and pin 4.3 low let the disable register be written.
//
// Chosen here: the APB slave port.
module gpc_pin_config_bank
    import gpc_pkg::*;
(
    input  wire logic                 pclk,                   // APB clock
    input  wire logic                 presetn,                // Standby POR, low
    input  wire logic                 main_reset,             // Main POR or hard reset
    input  wire logic                 psel,                   // APB select
    input  wire logic                 penable,                // APB enable
    input  wire logic                 pwrite,                 // APB write
    input  wire logic [GPC_AW-1:0]    paddr,                  // APB byte address
    input  wire logic [31:0]          pwdata,                 // APB write data
    output logic      [31:0]          prdata,                 // APB read data
    output logic                      pready,                 // APB ready
    output logic                      pslverr,                // APB error
    input  wire logic [GPC_NPINS-1:0] pin_in,                 // Pad input levels
    output logic      [GPC_NPINS-1:0] pin_out,                // Pad output levels
    output logic      [GPC_NPINS-1:0] pin_oe,                 // Pad drive enables
    input  wire logic                 address_line_mask,      // Mask function level
    input  wire logic                 drive_density_select_0, // Density select 0
    input  wire logic                 drive_density_select_1, // Density select 1
    input  wire logic                 power_event_req,        // Power event, high
    output logic                      ddr_writable,           // Disable reg writable
    output logic                      irq                     // Interrupt, high
);
    // ****************************************************************
    // Storage
    // ****************************************************************
    gpc_cfg_s               cfg_reg  [GPC_NPINS];
    gpc_cfg_s               cfg_next [GPC_NPINS];
    logic [GPC_NPINS-1:0]   dout_reg;
    logic [GPC_NPINS-1:0]   dout_next;
    logic [GPC_NPINS-1:0]   din_reg;
    logic [GPC_NPINS-1:0]   prev_reg;
    logic [GPC_IRQ_W-1:0]   ist_reg;
    logic [GPC_IRQ_W-1:0]   ist_next;
    logic [GPC_IRQ_W-1:0]   imsk_reg;
    logic [GPC_IRQ_W-1:0]   imsk_next;
    logic [31:0]            prdata_reg;
    logic                   pready_reg;
    logic                   pslverr_reg;
    logic [GPC_NPINS-1:0]   pin_out_reg;
    logic [GPC_NPINS-1:0]   pin_oe_reg;
    logic                   ddr_wr_reg;
    logic                   irq_reg;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire        [7:0] reg_idx  = paddr[9:2];
    wire              aligned  = (paddr[1:0] == 2'h0) && (paddr[GPC_AW-1:10] == '0);
    wire              setup    = psel && !penable;
    wire              wr_en    = psel && penable && pwrite && pready_reg;
    wire              hit_dout = aligned && (reg_idx == GPC_IDX_DOUT);
    wire              hit_din  = aligned && (reg_idx == GPC_IDX_DIN);
    wire              hit_ist  = aligned && (reg_idx == GPC_IDX_IST);
    wire              hit_imsk = aligned && (reg_idx == GPC_IDX_IMSK);
    wire              hit_lock = aligned && (reg_idx == GPC_IDX_LOCK);
    logic [GPC_NPINS-1:0] hit_cfg;
    wire              hit_any  = (|hit_cfg) || hit_dout || hit_din || hit_ist
                                 || hit_imsk || hit_lock;

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    wire lock_mode = (cfg_reg[GPC_P43].alt == GPC_ALT43_LCK);
    wire edge2_on  = (cfg_reg[GPC_P41].alt == GPC_ALT41_EDG);
    wire edge3_on  = (cfg_reg[GPC_P43].alt == GPC_ALT43_EDG);
    logic [GPC_NPINS-1:0] alt_on;
    logic [GPC_NPINS-1:0] alt_val;
    logic [GPC_NPINS-1:0] force_in;
    logic [GPC_NPINS-1:0] in_val;
    logic [GPC_NPINS-1:0] oe_next;
    logic [GPC_NPINS-1:0] out_next;

    assign alt_on[GPC_P37]  = cfg_reg[GPC_P37].alt[0];
    assign alt_val[GPC_P37] = address_line_mask;
    assign alt_on[GPC_P40]  = cfg_reg[GPC_P40].alt[0];
    assign alt_val[GPC_P40] = drive_density_select_0;
    assign alt_on[GPC_P41]  = (cfg_reg[GPC_P41].alt == GPC_ALT41_DEN);
    assign alt_val[GPC_P41] = drive_density_select_1;
    assign alt_on[GPC_P42]  = cfg_reg[GPC_P42].alt[0];
    assign alt_val[GPC_P42] = !power_event_req;
    assign alt_on[GPC_P43]  = 1'b0;
    assign alt_val[GPC_P43] = 1'b0;
    assign alt_on[GPC_P50]  = 1'b0;
    assign alt_val[GPC_P50] = 1'b0;
    assign force_in         = lock_mode ? (GPC_NPINS)'(1 << GPC_P43) : '0;

    // ****************************************************************
    // Per-pin drive and configuration update
    // ****************************************************************
    for (genvar i = 0; i < GPC_NPINS; i++) begin : g_pin
        wire [7:0] merged = (cfg_reg[i] & ~GPC_CFG_WMASK[i])
                            | (pwdata[7:0] & GPC_CFG_WMASK[i]);
        wire [7:0] wr_val = (wr_en && hit_cfg[i]) ? merged : cfg_reg[i];
        wire       core   = alt_on[i] ? alt_val[i] : dout_reg[i];
        wire       inv    = cfg_reg[i].invert && !force_in[i];
        wire       drv    = core ^ inv;
        wire       is_out = !cfg_reg[i].dir_in && !force_in[i];
        assign hit_cfg[i] = aligned && (reg_idx == GPC_CFG_IDX[i]);
        assign in_val[i]  = pin_in[i] ^ inv;
        assign oe_next[i]  = is_out && (!cfg_reg[i].open_drain || !drv);
        assign out_next[i] = is_out && !cfg_reg[i].open_drain && drv;
        if (i == GPC_P43) begin : g_lock
            wire [1:0] alt43 = main_reset ? GPC_ALT_GPIO :
                               lock_mode ? cfg_reg[i].alt : wr_val[3:2];
            assign cfg_next[i] = gpc_cfg_s'({wr_val[7:4], alt43, wr_val[1:0]});
        end else begin : g_plain
            assign cfg_next[i] = gpc_cfg_s'(wr_val);
        end
        a_dir_input_oe: assert property (@(posedge pclk) disable iff (!presetn)
            cfg_reg[i].dir_in |=> !pin_oe[i])
            else $error("Input pin is driven.");
        a_open_drain_hi: assert property (@(posedge pclk) disable iff (!presetn)
            cfg_reg[i].open_drain |=> !(pin_oe[i] && pin_out[i]))
            else $error("Open drain pin drives high.");
        a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
            cfg_reg[i].rsvd == 3'h0)
            else $error("Reserved bits are set.");
        a_cfg_write: assert property (@(posedge pclk) disable iff (!presetn)
            (wr_en && hit_cfg[i] && !lock_mode && !main_reset) |=>
            cfg_reg[i] == gpc_cfg_s'($past(pwdata[7:0]) & GPC_CFG_WMASK[i]))
            else $error("Config write not as masked.");
        a_dir_output_oe: assert property (@(posedge pclk) disable iff (!presetn)
            (!cfg_reg[i].dir_in && !cfg_reg[i].open_drain && !force_in[i]) |=> pin_oe[i])
            else $error("Push-pull output not driven.");
    end

    // ****************************************************************
    // Interrupt events and software registers
    // ****************************************************************
    logic [GPC_IRQ_W-1:0] ev;
    wire                  chg = |(in_val ^ prev_reg);
    assign ev[GPC_IRQ_EDGE2] = edge2_on && (in_val[GPC_P41] != prev_reg[GPC_P41]);
    assign ev[GPC_IRQ_EDGE3] = edge3_on && (in_val[GPC_P43] != prev_reg[GPC_P43]);
    assign ev[GPC_IRQ_LOCK]  = lock_mode && (in_val[GPC_P43] != prev_reg[GPC_P43]);
    wire [GPC_IRQ_W-1:0] w1c = (wr_en && hit_ist) ? pwdata[GPC_IRQ_W-1:0] : '0;
    assign ist_next  = (ist_reg & ~w1c) | ev;
    assign imsk_next = (wr_en && hit_imsk) ? pwdata[GPC_IRQ_W-1:0] : imsk_reg;
    assign dout_next = (wr_en && hit_dout) ? pwdata[GPC_NPINS-1:0] : dout_reg;

    a_lock_flag: assert property (@(posedge pclk) disable iff (!presetn)
        ev[GPC_IRQ_LOCK] |=> ist_reg[GPC_IRQ_LOCK])
        else $error("Lock pin change not flagged.");

    a_status_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_ist && pwdata[GPC_IRQ_EDGE2] && !ev[GPC_IRQ_EDGE2]) |=>
        !ist_reg[GPC_IRQ_EDGE2])
        else $error("Status bit not cleared.");

    a_edge2_only: assert property (@(posedge pclk) disable iff (!presetn)
        (!edge2_on && !ist_reg[GPC_IRQ_EDGE2]) |=> !ist_reg[GPC_IRQ_EDGE2])
        else $error("Edge 2 flagged outside its mode.");

    a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_imsk) |=> imsk_reg == $past(pwdata[GPC_IRQ_W-1:0]))
        else $error("Mask write lost.");

    a_dout_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_dout) |=> dout_reg == $past(pwdata[GPC_NPINS-1:0]))
        else $error("Data write lost.");

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [7:0] cfg_rd;
    always_comb begin
        cfg_rd = 8'h00;
        for (int k = 0; k < GPC_NPINS; k++) begin
            cfg_rd = cfg_rd | (hit_cfg[k] ? cfg_reg[k] : 8'h00);
        end
    end
    wire [31:0] rd_mux = {24'h000000, cfg_rd}
                       | (hit_dout ? {26'h0, dout_reg} : 32'h0)
                       | (hit_din  ? {26'h0, din_reg}  : 32'h0)
                       | (hit_ist  ? {29'h0, ist_reg}  : 32'h0)
                       | (hit_imsk ? {29'h0, imsk_reg} : 32'h0)
                       | (hit_lock ? {30'h0, ddr_wr_reg, lock_mode} : 32'h0);

    // ****************************************************************
    // Clocked state
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < GPC_NPINS; k++) begin
                cfg_reg[k] <= gpc_cfg_s'(GPC_CFG_RST);
            end
            dout_reg <= '0;
            din_reg  <= '0;
            prev_reg <= '0;
            ist_reg  <= '0;
            imsk_reg <= '0;
        end else begin
            for (int k = 0; k < GPC_NPINS; k++) begin
                cfg_reg[k] <= cfg_next[k];
            end
            dout_reg <= dout_next;
            din_reg  <= in_val;
            prev_reg <= in_val;
            ist_reg  <= ist_next;
            imsk_reg <= imsk_next;
        end
    end

    // Bus answer is prepared in the setup cycle, so access has no wait.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h00000000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup && !hit_any;
            prdata_reg  <= (setup && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // ****************************************************************
    // Bus protocol checks
    // ****************************************************************
    a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready)
        else $error("No answer after setup.");

    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("Ready held too long.");

    a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !hit_any) |=> (pready && pslverr))
        else $error("Unmapped access not refused.");

    a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && hit_any) |=> !pslverr)
        else $error("Mapped access refused.");

    a_read_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> (prdata == 32'h00000000))
        else $error("Read data outside access.");

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_reg <= '0;
            pin_oe_reg  <= '0;
            ddr_wr_reg  <= 1'b1;
            irq_reg     <= 1'b0;
        end else begin
            pin_out_reg <= out_next;
            pin_oe_reg  <= oe_next;
            ddr_wr_reg  <= !(lock_mode && pin_in[GPC_P43]);
            irq_reg     <= |(ist_next & imsk_next);
        end
    end

    // ****************************************************************
    // Lock mode checks
    // ****************************************************************
    a_main_clears: assert property (@(posedge pclk) disable iff (!presetn)
        main_reset |=> (cfg_reg[GPC_P43].alt == GPC_ALT_GPIO))
        else $error("Main reset left pin 4.3 mode.");

    a_lock_write_kept: assert property (@(posedge pclk) disable iff (!presetn)
        (lock_mode && !main_reset && wr_en && hit_cfg[GPC_P43]) |=>
        (cfg_reg[GPC_P43][1:0] == $past(pwdata[1:0])))
        else $error("Lock mode blocked other bits.");

    a_lock_plain_in: assert property (@(posedge pclk) disable iff (!presetn)
        lock_mode |-> (in_val[GPC_P43] == pin_in[GPC_P43]))
        else $error("Lock pin input inverted.");

    a_unlocked_ddr: assert property (@(posedge pclk) disable iff (!presetn)
        !lock_mode |=> ddr_writable)
        else $error("Disable register locked outside lock mode.");

    assign prdata       = prdata_reg;
    assign pready       = pready_reg;
    assign pslverr      = pslverr_reg;
    assign pin_out      = pin_out_reg;
    assign pin_oe       = pin_oe_reg;
    assign ddr_writable = ddr_wr_reg;
    assign irq          = irq_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_polarity_in: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_reg[GPC_P37].invert && !chg) |=> din_reg[GPC_P37] == !$past(pin_in[GPC_P37]))
        else $error("Input polarity wrong.");
    a_mask_route: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_reg[GPC_P37] == gpc_cfg_s'(8'h04)) |=>
        pin_oe[GPC_P37] && pin_out[GPC_P37] == $past(address_line_mask))
        else $error("Mask function not routed.");
    a_density0_out: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_reg[GPC_P40] == gpc_cfg_s'(8'h04)) |=>
        pin_out[GPC_P40] == $past(drive_density_select_0))
        else $error("Density select 0 not routed.");
    a_density1_out: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_reg[GPC_P41] == gpc_cfg_s'(8'h04)) |=>
        pin_out[GPC_P41] == $past(drive_density_select_1))
        else $error("Density select 1 not routed.");
    a_edge2_flag: assert property (@(posedge pclk) disable iff (!presetn)
        ev[GPC_IRQ_EDGE2] |=> ist_reg[GPC_IRQ_EDGE2])
        else $error("Edge 2 not flagged.");
    a_pme_active_low: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_reg[GPC_P42] == gpc_cfg_s'(8'h04) && power_event_req) |=>
        pin_oe[GPC_P42] && !pin_out[GPC_P42])
        else $error("Power event not low.");
    a_edge3_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (edge3_on && in_val[GPC_P43] != prev_reg[GPC_P43]) |=> ist_reg[GPC_IRQ_EDGE3])
        else $error("Edge 3 not flagged.");
    a_lock_input: assert property (@(posedge pclk) disable iff (!presetn)
        lock_mode |=> !pin_oe[GPC_P43])
        else $error("Lock pin driven.");
    a_lock_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (lock_mode && !main_reset) |=> lock_mode)
        else $error("Lock mode left without reset.");
    a_ddr_readonly: assert property (@(posedge pclk) disable iff (!presetn)
        (lock_mode && pin_in[GPC_P43]) |=> !ddr_writable)
        else $error("Disable register not locked.");
    a_ddr_writable: assert property (@(posedge pclk) disable iff (!presetn)
        (lock_mode && !pin_in[GPC_P43]) |=> ddr_writable)
        else $error("Disable register not writable.");
    a_alt_replaces: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_reg[GPC_P42] == gpc_cfg_s'(8'h06)) |=>
        pin_out[GPC_P42] == $past(power_event_req))
        else $error("Inverted function not carried.");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(ist_reg & imsk_reg))
        else $error("Interrupt level wrong.");
    a_gpio_data: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_reg[GPC_P50] == gpc_cfg_s'(8'h00)) |=>
        (pin_oe[GPC_P50] && pin_out[GPC_P50] == $past(dout_reg[GPC_P50])))
        else $error("Plain output not carried.");
    a_rsvd41_gpio: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_reg[GPC_P41] == gpc_cfg_s'(8'h0C)) |=> pin_out[GPC_P41] == $past(dout_reg[GPC_P41]))
        else $error("Reserved mode not plain output.");
endmodule

// *** test/gpc_pin_config_bank_tb_top.sv ***
// Purpose: Self-checking bench for the pin configuration bank.
// Assumes: Zero-wait APB slave; pin outputs settle within three cycles.
// Notes:   Table rows cover pin drive; interrupts and lock mode follow.
module gpc_pin_config_bank_tb_top
    import gpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // Signals and table
    // ****************************************************************
    typedef struct packed {
        logic [2:0] slot;
        logic [7:0] cfg;
        logic       dout;
        logic [3:0] fn;
        logic       oe;
        logic       out;
    } gpc_row_s;
    localparam gpc_row_s ROWS [15] = '{
        '{3'h0, 8'h00, 1'b1, 4'h0, 1'b1, 1'b1}, '{3'h0, 8'h02, 1'b1, 4'h0, 1'b1, 1'b0},
        '{3'h0, 8'h80, 1'b1, 4'h0, 1'b0, 1'b0}, '{3'h0, 8'h80, 1'b0, 4'h0, 1'b1, 1'b0},
        '{3'h0, 8'h01, 1'b1, 4'h0, 1'b0, 1'b0}, '{3'h0, 8'h04, 1'b0, 4'h8, 1'b1, 1'b1},
        '{3'h0, 8'h06, 1'b0, 4'h8, 1'b1, 1'b0}, '{3'h1, 8'h04, 1'b0, 4'h4, 1'b1, 1'b1},
        '{3'h2, 8'h04, 1'b0, 4'h2, 1'b1, 1'b1}, '{3'h2, 8'h0C, 1'b0, 4'h2, 1'b1, 1'b0},
        '{3'h3, 8'h04, 1'b0, 4'h1, 1'b1, 1'b0}, '{3'h3, 8'h06, 1'b0, 4'h1, 1'b1, 1'b1},
        '{3'h3, 8'h84, 1'b0, 4'h1, 1'b1, 1'b0}, '{3'h3, 8'h84, 1'b0, 4'h0, 1'b0, 1'b0},
        '{3'h5, 8'h00, 1'b1, 4'h0, 1'b1, 1'b1}};
    logic                 pclk;
    logic                 presetn;
    logic                 main_reset;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [GPC_AW-1:0]    paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic [GPC_NPINS-1:0] pin_in;
    logic [GPC_NPINS-1:0] pin_out;
    logic [GPC_NPINS-1:0] pin_oe;
    logic [3:0]           fn;
    logic                 ddr_writable;
    logic                 irq;
    int                   miscompares;
    int                   comparisons;
    logic [31:0]          rdata;
    logic                 rerr;
    gpc_row_s             r;

    gpc_pin_config_bank i_dut (
        .pclk                   (pclk),
        .presetn                (presetn),
        .main_reset             (main_reset),
        .psel                   (psel),
        .penable                (penable),
        .pwrite                 (pwrite),
        .paddr                  (paddr),
        .pwdata                 (pwdata),
        .prdata                 (prdata),
        .pready                 (pready),
        .pslverr                (pslverr),
        .pin_in                 (pin_in),
        .pin_out                (pin_out),
        .pin_oe                 (pin_oe),
        .address_line_mask      (fn[3]),
        .drive_density_select_0 (fn[2]),
        .drive_density_select_1 (fn[1]),
        .power_event_req        (fn[0]),
        .ddr_writable           (ddr_writable),
        .irq                    (irq)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic conclude();
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Called just after a rising edge; ends one idle cycle after the access edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            conclude();
        end
        @(posedge pclk);
    endtask

    function automatic logic [11:0] cfg_addr(input int s);
        return {2'h0, GPC_CFG_IDX[s], 2'h0};
    endfunction

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, rdata, exp);
        chk("pslverr", {31'h0, rerr}, 32'h0);
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        miscompares = 0;
        comparisons = 0;
        presetn = 1'b0;
        main_reset = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pin_in = 6'h00;
        fn = 4'h0;
        cyc(12);
        presetn <= 1'b1;
        cyc(2);
        chk("pin_oe", {26'h0, pin_oe}, 32'h0);
        chk("ddr_writable", {31'h0, ddr_writable}, 32'h1);
        for (int s = 0; s < GPC_NPINS; s++) begin
            rd_chk("cfg_reset", cfg_addr(s), 32'h1);
            apb(1'b1, cfg_addr(s), 32'hFF);
            rd_chk("cfg_mask", cfg_addr(s), {24'h0, GPC_CFG_WMASK[s]});
            apb(1'b1, cfg_addr(s), 32'h01);
        end
        apb(1'b0, 12'h200, 32'h0);
        chk("unmapped", {rerr, rdata[30:0]}, 32'h80000000);
        for (int i = 0; i < 15; i++) begin
            r = ROWS[i];
            apb(1'b1, cfg_addr(int'(r.slot)), {24'h0, r.cfg});
            apb(1'b1, 12'h120, {26'h0, {6{r.dout}}});
            fn <= r.fn;
            cyc(3);
            chk("pin_oe", {31'h0, pin_oe[r.slot]}, {31'h0, r.oe});
            if (r.oe) begin
                chk("pin_out", {31'h0, pin_out[r.slot]}, {31'h0, r.out});
            end
        end
        apb(1'b1, cfg_addr(GPC_P50), 32'h03);
        pin_in <= 6'h20;
        cyc(3);
        rd_chk("din", 12'h124, 32'h01);
        apb(1'b1, cfg_addr(GPC_P41), 32'h09);
        apb(1'b1, cfg_addr(GPC_P43), 32'h0D);
        apb(1'b1, 12'h128, 32'h7);
        pin_in <= 6'h24;
        cyc(3);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        rd_chk("status", 12'h128, 32'h1);
        apb(1'b1, 12'h12C, 32'h3);
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, 12'h128, 32'h1);
        chk("irq_clear", {31'h0, irq}, 32'h0);
        pin_in <= 6'h34;
        cyc(3);
        rd_chk("status", 12'h128, 32'h2);
        apb(1'b1, 12'h128, 32'h7);
        apb(1'b1, cfg_addr(GPC_P43), 32'h01);
        apb(1'b1, cfg_addr(GPC_P43), 32'h06);
        apb(1'b1, cfg_addr(GPC_P43), 32'h0B);
        rd_chk("lock_keep", cfg_addr(GPC_P43), 32'h07);
        cyc(3);
        chk("lock_oe", {31'h0, pin_oe[GPC_P43]}, 32'h0);
        chk("ddr_high", {31'h0, ddr_writable}, 32'h0);
        pin_in <= 6'h24;
        cyc(3);
        chk("ddr_low", {31'h0, ddr_writable}, 32'h1);
        main_reset <= 1'b1;
        cyc(1);
        main_reset <= 1'b0;
        cyc(2);
        rd_chk("main_reset", cfg_addr(GPC_P43), 32'h03);
        conclude();
    end
endmodule
